// File: core/foc_result_pkg.sv
// Constants for the FOC result and parameter register bank
package foc_result_pkg;

	localparam int          ADDR_W = 18;
	localparam int          IDX_W  = 16;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_ANGLE_COMP_H  = 16'h40AE;
	localparam logic [15:0] IDX_ANGLE_COMP_L  = 16'h40AF;
	localparam logic [15:0] IDX_Q_LIMIT_H     = 16'h40B4;
	localparam logic [15:0] IDX_Q_LIMIT_L     = 16'h40B5;
	localparam logic [15:0] IDX_D_VOLT_H      = 16'h40B8;
	localparam logic [15:0] IDX_D_VOLT_L      = 16'h40B9;
	localparam logic [15:0] IDX_Q_VOLT_H      = 16'h40BA;
	localparam logic [15:0] IDX_Q_VOLT_L      = 16'h40BB;
	localparam logic [15:0] IDX_D_CUR_H       = 16'h40BC;
	localparam logic [15:0] IDX_D_CUR_L       = 16'h40BD;
	localparam logic [15:0] IDX_Q_CUR_H       = 16'h40BE;
	localparam logic [15:0] IDX_Q_CUR_L       = 16'h40BF;
	localparam logic [15:0] IDX_BETA_CUR_H    = 16'h40C0;
	localparam logic [15:0] IDX_BETA_CUR_L    = 16'h40C1;
	localparam logic [15:0] IDX_BETA_VOLT_H   = 16'h40C2;
	localparam logic [15:0] IDX_BETA_VOLT_L   = 16'h40C3;
	localparam logic [15:0] IDX_ALPHA_VOLT_H  = 16'h40C4;
	localparam logic [15:0] IDX_ALPHA_VOLT_L  = 16'h40C5;
	localparam logic [15:0] IDX_PHASE_C_H     = 16'h40C6;
	localparam logic [15:0] IDX_PHASE_C_L     = 16'h40C7;
	localparam logic [15:0] IDX_PHASE_B_H     = 16'h40C8;
	localparam logic [15:0] IDX_PHASE_B_L     = 16'h40C9;
	localparam logic [15:0] IDX_PHASE_A_H     = 16'h40CA;
	localparam logic [15:0] IDX_PHASE_A_L     = 16'h40CB;
	localparam logic [15:0] IDX_OUT_ANGLE_H   = 16'h40CC;
	localparam logic [15:0] IDX_OUT_ANGLE_L   = 16'h40CD;
	localparam logic [15:0] IDX_EST_ANGLE_H   = 16'h40CE;
	localparam logic [15:0] IDX_EST_ANGLE_L   = 16'h40CF;
	localparam logic [15:0] IDX_ALPHA_BEMF_H  = 16'h40D0;
	localparam logic [15:0] IDX_ALPHA_BEMF_L  = 16'h40D1;
	localparam logic [15:0] IDX_BETA_BEMF_H   = 16'h40D2;
	localparam logic [15:0] IDX_BETA_BEMF_L   = 16'h40D3;
	localparam logic [15:0] IDX_SPEED_H       = 16'h40D4;
	localparam logic [15:0] IDX_SPEED_L       = 16'h40D5;
	localparam logic [15:0] IDX_Q_OVF_H       = 16'h40D6;
	localparam logic [15:0] IDX_Q_OVF_L       = 16'h40D7;

	// Values after reset
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [7:0]  RST_FILT_COEF = 8'hFF;

endpackage

// File: core/foc_result_regs.sv
// Avalon-MM register bank for FOC results, compensation and motor parameters
`timescale 1ns/1ps
module foc_result_regs (
	input  wire logic                               core_clk_in,           // System clock
	input  wire logic                               rstn_in,               // Async reset, low
	input  wire logic [foc_result_pkg::ADDR_W-1:0]  avs_address_in,        // Byte address
	input  wire logic                               avs_read_in,           // Read request
	input  wire logic                               avs_write_in,          // Write request
	input  wire logic [31:0]                        avs_writedata_in,      // Write data
	input  wire logic [3:0]                         avs_byteenable_in,     // Byte enables
	output logic      [31:0]                        avs_readdata_out,      // Read data
	output logic                                    avs_waitrequest_out,   // Wait request
	input  wire logic                               eng_update_in,         // Engine results valid
	input  wire logic [15:0]                        eng_q_voltage_in,      // q controller output
	input  wire logic [15:0]                        eng_d_voltage_in,      // d controller output
	input  wire logic [15:0]                        eng_d_current_in,      // d-axis current
	input  wire logic [15:0]                        eng_q_current_in,      // q-axis current
	input  wire logic [15:0]                        eng_beta_current_in,   // beta-axis current
	input  wire logic [15:0]                        eng_beta_voltage_in,   // beta output voltage
	input  wire logic [15:0]                        eng_alpha_voltage_in,  // alpha output voltage
	input  wire logic [15:0]                        eng_phase_a_in,        // Phase A sample
	input  wire logic [15:0]                        eng_phase_b_in,        // Phase B sample
	input  wire logic [15:0]                        eng_phase_c_in,        // Phase C sample
	input  wire logic [15:0]                        eng_alpha_bemf_in,     // alpha back-EMF
	input  wire logic [15:0]                        eng_beta_bemf_in,      // beta back-EMF
	input  wire logic [15:0]                        eng_est_angle_in,      // Estimator angle
	input  wire logic [15:0]                        eng_speed_in,          // Estimator speed
	output logic      [7:0]                         q_filter_coef_out,     // q filter coef
	output logic      [7:0]                         d_filter_coef_out,     // d filter coef
	output logic      [15:0]                        motor_flux_out,        // Motor flux
	output logic      [15:0]                        q_inductance_out,      // q inductance
	output logic      [15:0]                        d_inductance_out,      // d inductance
	output logic      [15:0]                        q_limit_out,           // q upper limit
	output logic      [15:0]                        d_voltage_sum_out,     // d voltage + comp
	output logic      [15:0]                        q_voltage_sum_out,     // q voltage + comp
	output logic      [15:0]                        output_angle_out,      // Output angle
	output logic      [15:0]                        speed_out,             // Estimator speed
	output logic      [15:0]                        est_start_angle_out,   // Start angle
	output logic                                    est_start_load_out,    // Start angle pulse
	output logic      [15:0]                        q_overflow_out         // q overflow
);

	// Replace one byte of a 16-bit entry; high byte sits at the even index
	function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi,
		input logic [7:0] b);
		logic [15:0] r;
		r = v;
		if (hi) begin
			r[15:8] = b;
		end else begin
			r[7:0] = b;
		end
		return r;
	endfunction

	function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic hi);
		return hi ? v[15:8] : v[7:0];
	endfunction

	// Bus state
	logic        wait_q,  wait_d;
	logic [31:0] rdata_q, rdata_d;

	// Stored entries
	logic [7:0]  q_coef_q,   q_coef_d;
	logic [7:0]  d_coef_q,   d_coef_d;
	logic [15:0] q_volt_q,   q_volt_d;
	logic [15:0] d_volt_q,   d_volt_d;
	logic [15:0] q_lim_q,    q_lim_d;
	logic [15:0] d_comp_q,   d_comp_d;
	logic [15:0] q_comp_q,   q_comp_d;
	logic [15:0] a_comp_q,   a_comp_d;
	logic [15:0] flux_q,     flux_d;
	logic [15:0] lq_q,       lq_d;
	logic [15:0] ld_q,       ld_d;
	logic [15:0] d_cur_q,    d_cur_d;
	logic [15:0] q_cur_q,    q_cur_d;
	logic [15:0] b_cur_q,    b_cur_d;
	logic [15:0] b_volt_q,   b_volt_d;
	logic [15:0] a_volt_q,   a_volt_d;
	logic [15:0] ph_a_q,     ph_a_d;
	logic [15:0] ph_b_q,     ph_b_d;
	logic [15:0] ph_c_q,     ph_c_d;
	logic [15:0] a_bemf_q,   a_bemf_d;
	logic [15:0] b_bemf_q,   b_bemf_d;
	logic [15:0] est_ang_q,  est_ang_d;
	logic [15:0] out_ang_q,  out_ang_d;
	logic [15:0] speed_q,    speed_d;
	logic [15:0] start_q,    start_d;
	logic        load_q,     load_d;
	logic [15:0] d_sum_q,    d_sum_d;
	logic [15:0] q_sum_q,    q_sum_d;
	logic [15:0] ovf_q,      ovf_d;

	// Decode
	logic [15:0] idx;
	logic        aligned;
	logic        hi;
	logic        req;
	logic        wr_go;
	logic [7:0]  wbyte;

	assign idx     = avs_address_in[17:2];
	assign aligned = (avs_address_in[1:0] == 2'h0);
	assign hi      = ~idx[0];
	assign req     = avs_read_in | avs_write_in;
	assign wr_go   = avs_write_in & ~wait_q & aligned & avs_byteenable_in[0];
	assign wbyte   = avs_writedata_in[7:0];

	// One wait cycle per access, then completion
	always_comb begin
		logic [7:0] rb;
		rb      = 8'h00;
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if (req && wait_q) begin
			wait_d = 1'b0;
			if (aligned) begin
				case (idx)
					foc_result_pkg::IDX_Q_LIMIT_H,
					foc_result_pkg::IDX_Q_LIMIT_L:    rb = pick_byte(q_lim_q, hi);
					foc_result_pkg::IDX_D_VOLT_H,
					foc_result_pkg::IDX_D_VOLT_L:     rb = pick_byte(d_volt_q, hi);
					foc_result_pkg::IDX_Q_VOLT_H,
					foc_result_pkg::IDX_Q_VOLT_L:     rb = pick_byte(q_volt_q, hi);
					foc_result_pkg::IDX_D_CUR_H,
					foc_result_pkg::IDX_D_CUR_L:      rb = pick_byte(d_cur_q, hi);
					foc_result_pkg::IDX_Q_CUR_H,
					foc_result_pkg::IDX_Q_CUR_L:      rb = pick_byte(q_cur_q, hi);
					foc_result_pkg::IDX_BETA_CUR_H,
					foc_result_pkg::IDX_BETA_CUR_L:   rb = pick_byte(b_cur_q, hi);
					foc_result_pkg::IDX_BETA_VOLT_H,
					foc_result_pkg::IDX_BETA_VOLT_L:  rb = pick_byte(b_volt_q, hi);
					foc_result_pkg::IDX_ALPHA_VOLT_H,
					foc_result_pkg::IDX_ALPHA_VOLT_L: rb = pick_byte(a_volt_q, hi);
					foc_result_pkg::IDX_PHASE_C_H,
					foc_result_pkg::IDX_PHASE_C_L:    rb = pick_byte(ph_c_q, hi);
					foc_result_pkg::IDX_PHASE_B_H,
					foc_result_pkg::IDX_PHASE_B_L:    rb = pick_byte(ph_b_q, hi);
					foc_result_pkg::IDX_PHASE_A_H,
					foc_result_pkg::IDX_PHASE_A_L:    rb = pick_byte(ph_a_q, hi);
					foc_result_pkg::IDX_OUT_ANGLE_H,
					foc_result_pkg::IDX_OUT_ANGLE_L:  rb = pick_byte(out_ang_q, hi);
					foc_result_pkg::IDX_EST_ANGLE_H,
					foc_result_pkg::IDX_EST_ANGLE_L:  rb = pick_byte(est_ang_q, hi);
					foc_result_pkg::IDX_ALPHA_BEMF_H,
					foc_result_pkg::IDX_ALPHA_BEMF_L: rb = pick_byte(a_bemf_q, hi);
					foc_result_pkg::IDX_BETA_BEMF_H,
					foc_result_pkg::IDX_BETA_BEMF_L:  rb = pick_byte(b_bemf_q, hi);
					foc_result_pkg::IDX_SPEED_H,
					foc_result_pkg::IDX_SPEED_L:      rb = pick_byte(speed_q, hi);
					foc_result_pkg::IDX_Q_OVF_H,
					foc_result_pkg::IDX_Q_OVF_L:      rb = pick_byte(ovf_q, hi);
					default:                          rb = 8'h00;
				endcase
			end
			rdata_d = {24'h000000, rb};
		end
	end

	// Engine updates, then software writes on top of them
	always_comb begin
		q_coef_d  = q_coef_q;
		d_coef_d  = d_coef_q;
		q_lim_d   = q_lim_q;
		d_comp_d  = d_comp_q;
		q_comp_d  = q_comp_q;
		a_comp_d  = a_comp_q;
		flux_d    = flux_q;
		lq_d      = lq_q;
		ld_d      = ld_q;
		start_d   = start_q;
		load_d    = 1'b0;
		q_volt_d  = q_volt_q;
		d_volt_d  = d_volt_q;
		d_cur_d   = d_cur_q;
		q_cur_d   = q_cur_q;
		b_cur_d   = b_cur_q;
		b_volt_d  = b_volt_q;
		a_volt_d  = a_volt_q;
		ph_a_d    = ph_a_q;
		ph_b_d    = ph_b_q;
		ph_c_d    = ph_c_q;
		a_bemf_d  = a_bemf_q;
		b_bemf_d  = b_bemf_q;
		est_ang_d = est_ang_q;
		out_ang_d = out_ang_q;
		speed_d   = speed_q;
		if (eng_update_in) begin
			q_volt_d  = eng_q_voltage_in;
			d_volt_d  = eng_d_voltage_in;
			d_cur_d   = eng_d_current_in;
			q_cur_d   = eng_q_current_in;
			b_cur_d   = eng_beta_current_in;
			b_volt_d  = eng_beta_voltage_in;
			a_volt_d  = eng_alpha_voltage_in;
			ph_a_d    = eng_phase_a_in;
			ph_b_d    = eng_phase_b_in;
			ph_c_d    = eng_phase_c_in;
			a_bemf_d  = eng_alpha_bemf_in;
			b_bemf_d  = eng_beta_bemf_in;
			est_ang_d = eng_est_angle_in;
			out_ang_d = 16'(eng_est_angle_in + a_comp_q);
			speed_d   = eng_speed_in;
		end
		if (wr_go) begin
			case (idx)
				foc_result_pkg::IDX_ANGLE_COMP_H,
				foc_result_pkg::IDX_ANGLE_COMP_L: a_comp_d  = put_byte(a_comp_q, hi, wbyte);
				foc_result_pkg::IDX_Q_LIMIT_H,
				foc_result_pkg::IDX_Q_LIMIT_L:    q_lim_d   = put_byte(q_lim_q, hi, wbyte);
				foc_result_pkg::IDX_D_VOLT_H,
				foc_result_pkg::IDX_D_VOLT_L:     d_volt_d  = put_byte(d_volt_q, hi, wbyte);
				foc_result_pkg::IDX_Q_VOLT_H,
				foc_result_pkg::IDX_Q_VOLT_L:     q_volt_d  = put_byte(q_volt_q, hi, wbyte);
				foc_result_pkg::IDX_BETA_CUR_H:   q_coef_d  = wbyte;
				foc_result_pkg::IDX_BETA_CUR_L:   d_coef_d  = wbyte;
				foc_result_pkg::IDX_BETA_VOLT_H,
				foc_result_pkg::IDX_BETA_VOLT_L:  d_comp_d  = put_byte(d_comp_q, hi, wbyte);
				foc_result_pkg::IDX_ALPHA_VOLT_H,
				foc_result_pkg::IDX_ALPHA_VOLT_L: q_comp_d  = put_byte(q_comp_q, hi, wbyte);
				foc_result_pkg::IDX_PHASE_C_H,
				foc_result_pkg::IDX_PHASE_C_L:    flux_d    = put_byte(flux_q, hi, wbyte);
				foc_result_pkg::IDX_PHASE_B_H,
				foc_result_pkg::IDX_PHASE_B_L:    lq_d      = put_byte(lq_q, hi, wbyte);
				foc_result_pkg::IDX_PHASE_A_H,
				foc_result_pkg::IDX_PHASE_A_L:    ld_d      = put_byte(ld_q, hi, wbyte);
				foc_result_pkg::IDX_OUT_ANGLE_H,
				foc_result_pkg::IDX_OUT_ANGLE_L:  out_ang_d = put_byte(out_ang_q, hi, wbyte);
				foc_result_pkg::IDX_EST_ANGLE_H,
				foc_result_pkg::IDX_EST_ANGLE_L: begin
					start_d   = put_byte(start_q, hi, wbyte);
					est_ang_d = put_byte(start_q, hi, wbyte);
					load_d    = 1'b1;
				end
				foc_result_pkg::IDX_SPEED_H,
				foc_result_pkg::IDX_SPEED_L:      speed_d   = put_byte(speed_q, hi, wbyte);
				default: begin
				end
			endcase
		end
	end

	// Derived outputs, signed wrapping arithmetic
	always_comb begin
		d_sum_d = 16'(d_volt_q + d_comp_q);
		q_sum_d = 16'(q_volt_q + q_comp_q);
		ovf_d   = 16'($signed(q_volt_q) - $signed(q_lim_q));
	end

	always_ff @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_q    <= 1'b1;
			rdata_q   <= 32'h00000000;
			q_coef_q  <= foc_result_pkg::RST_FILT_COEF;
			d_coef_q  <= foc_result_pkg::RST_FILT_COEF;
			q_lim_q   <= foc_result_pkg::RST_WORD;
			d_comp_q  <= foc_result_pkg::RST_WORD;
			q_comp_q  <= foc_result_pkg::RST_WORD;
			a_comp_q  <= foc_result_pkg::RST_WORD;
			flux_q    <= foc_result_pkg::RST_WORD;
			lq_q      <= foc_result_pkg::RST_WORD;
			ld_q      <= foc_result_pkg::RST_WORD;
			start_q   <= foc_result_pkg::RST_WORD;
			load_q    <= 1'b0;
			q_volt_q  <= foc_result_pkg::RST_WORD;
			d_volt_q  <= foc_result_pkg::RST_WORD;
			d_cur_q   <= foc_result_pkg::RST_WORD;
			q_cur_q   <= foc_result_pkg::RST_WORD;
			b_cur_q   <= foc_result_pkg::RST_WORD;
			b_volt_q  <= foc_result_pkg::RST_WORD;
			a_volt_q  <= foc_result_pkg::RST_WORD;
			ph_a_q    <= foc_result_pkg::RST_WORD;
			ph_b_q    <= foc_result_pkg::RST_WORD;
			ph_c_q    <= foc_result_pkg::RST_WORD;
			a_bemf_q  <= foc_result_pkg::RST_WORD;
			b_bemf_q  <= foc_result_pkg::RST_WORD;
			est_ang_q <= foc_result_pkg::RST_WORD;
			out_ang_q <= foc_result_pkg::RST_WORD;
			speed_q   <= foc_result_pkg::RST_WORD;
			d_sum_q   <= foc_result_pkg::RST_WORD;
			q_sum_q   <= foc_result_pkg::RST_WORD;
			ovf_q     <= foc_result_pkg::RST_WORD;
		end else begin
			wait_q    <= wait_d;
			rdata_q   <= rdata_d;
			q_coef_q  <= q_coef_d;
			d_coef_q  <= d_coef_d;
			q_lim_q   <= q_lim_d;
			d_comp_q  <= d_comp_d;
			q_comp_q  <= q_comp_d;
			a_comp_q  <= a_comp_d;
			flux_q    <= flux_d;
			lq_q      <= lq_d;
			ld_q      <= ld_d;
			start_q   <= start_d;
			load_q    <= load_d;
			q_volt_q  <= q_volt_d;
			d_volt_q  <= d_volt_d;
			d_cur_q   <= d_cur_d;
			q_cur_q   <= q_cur_d;
			b_cur_q   <= b_cur_d;
			b_volt_q  <= b_volt_d;
			a_volt_q  <= a_volt_d;
			ph_a_q    <= ph_a_d;
			ph_b_q    <= ph_b_d;
			ph_c_q    <= ph_c_d;
			a_bemf_q  <= a_bemf_d;
			b_bemf_q  <= b_bemf_d;
			est_ang_q <= est_ang_d;
			out_ang_q <= out_ang_d;
			speed_q   <= speed_d;
			d_sum_q   <= d_sum_d;
			q_sum_q   <= q_sum_d;
			ovf_q     <= ovf_d;
		end
	end

	assign avs_readdata_out    = rdata_q;
	assign avs_waitrequest_out = wait_q;
	assign q_filter_coef_out   = q_coef_q;
	assign d_filter_coef_out   = d_coef_q;
	assign motor_flux_out      = flux_q;
	assign q_inductance_out    = lq_q;
	assign d_inductance_out    = ld_q;
	assign q_limit_out         = q_lim_q;
	assign d_voltage_sum_out   = d_sum_q;
	assign q_voltage_sum_out   = q_sum_q;
	assign output_angle_out    = out_ang_q;
	assign speed_out           = speed_q;
	assign est_start_angle_out = start_q;
	assign est_start_load_out  = load_q;
	assign q_overflow_out      = ovf_q;

endmodule

// File: verification/foc_result_regs_assertions.sv
// Port-level checker for the FOC result register bank
`timescale 1ns/1ps
module foc_result_regs_assertions (
	input wire logic        core_clk_in,         // Clock
	input wire logic        rstn_in,             // Reset, low
	input wire logic [17:0] avs_address_in,      // Byte address
	input wire logic        avs_read_in,         // Read
	input wire logic        avs_write_in,        // Write
	input wire logic [31:0] avs_writedata_in,    // Write data
	input wire logic [3:0]  avs_byteenable_in,   // Byte enables
	input wire logic [31:0] avs_readdata_out,    // Read data
	input wire logic        avs_waitrequest_out, // Wait request
	input wire logic        eng_update_in,       // Engine load
	input wire logic [15:0] eng_q_voltage_in,    // q controller
	input wire logic [15:0] eng_speed_in,        // Speed
	input wire logic [7:0]  q_filter_coef_out,   // q coef
	input wire logic [15:0] motor_flux_out,      // Flux
	input wire logic [15:0] q_limit_out,         // q limit
	input wire logic [15:0] speed_out,           // Speed entry
	input wire logic        est_start_load_out,  // Start pulse
	input wire logic [15:0] q_overflow_out       // q overflow
);
	wire        wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& avs_address_in[1:0] == 2'h0;
	wire        rd_ok = avs_read_in && !avs_waitrequest_out;
	wire [15:0] idx   = avs_address_in[17:2];

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence req_s; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
	sequence ans_s; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence

	bus_answer_a: assert property (req_s |=> ans_s)
		else $error("request not answered in one cycle");
	idle_wait_a: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
		else $error("answer without request");
	read_upper_a: assert property (rd_ok |-> avs_readdata_out[31:8] == 24'h0)
		else $error("read data upper bits set");
	unaligned_read_a: assert property (rd_ok && avs_address_in[1:0] != 2'h0
		|-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
	coef_write_a: assert property ($changed(q_filter_coef_out) |->
		$past(wr_ok && idx == 16'h40C0) && q_filter_coef_out == $past(avs_writedata_in[7:0]))
		else $error("q coef changed without write");
	flux_write_a: assert property ($changed(motor_flux_out) |->
		$past(wr_ok && idx inside {16'h40C6, 16'h40C7}) && ($past(idx[0]) ? motor_flux_out[7:0]
		: motor_flux_out[15:8]) == $past(avs_writedata_in[7:0])) else $error("flux mismatch");
	start_pulse_a: assert property (est_start_load_out ==
		$past(wr_ok && idx inside {16'h40CE, 16'h40CF})) else $error("start pulse mismatch");
	speed_load_a: assert property (eng_update_in && !(wr_ok && idx[15:1] == 15'h206A)
		|=> speed_out == $past(eng_speed_in)) else $error("speed not loaded");
	overflow_a: assert property (eng_update_in && !(wr_ok && idx[15:1] == 15'h205D)
		|-> ##2 q_overflow_out == $past(eng_q_voltage_in, 2) - $past(q_limit_out))
		else $error("q overflow wrong");
endmodule

bind foc_result_regs foc_result_regs_assertions chk (.*);

// File: verification/tb.sv
// Self-checking bench for the FOC result register bank
`timescale 1ns/1ps
module tb;
	logic        clk, rstn, rd, wr, upd, start_pulse;
	int          n_start = 0;
	logic [17:0] addr;
	logic [1:0]  lo;
	logic [31:0] wd, rdata;
	logic [3:0]  be;
	logic        wreq;
	logic [7:0]  cq, cd, kq, kd, b;
	logic [15:0] eng [14];
	logic [15:0] o16 [10];
	logic [15:0] rb [14];
	logic [15:0] rw [5];
	logic [15:0] w [5];
	logic [15:0] prm [5];
	logic [15:0] v, lim, ang;
	int          seed, k, p, n_checks, n_mismatch;

	foc_result_regs dut (
		.core_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .eng_update_in(upd),
		.eng_q_voltage_in(eng[0]), .eng_d_voltage_in(eng[1]), .eng_d_current_in(eng[2]),
		.eng_q_current_in(eng[3]), .eng_beta_current_in(eng[4]), .eng_beta_voltage_in(eng[5]),
		.eng_alpha_voltage_in(eng[6]), .eng_phase_a_in(eng[7]), .eng_phase_b_in(eng[8]),
		.eng_phase_c_in(eng[9]), .eng_alpha_bemf_in(eng[10]), .eng_beta_bemf_in(eng[11]),
		.eng_est_angle_in(eng[12]), .eng_speed_in(eng[13]), .q_filter_coef_out(cq),
		.d_filter_coef_out(cd), .motor_flux_out(o16[0]), .q_inductance_out(o16[1]),
		.d_inductance_out(o16[2]), .q_limit_out(o16[3]), .d_voltage_sum_out(o16[4]),
		.q_voltage_sum_out(o16[5]), .output_angle_out(o16[6]), .speed_out(o16[7]),
		.est_start_angle_out(o16[8]), .est_start_load_out(start_pulse),
		.q_overflow_out(o16[9]));

	// Start angle load pulses seen
	always @(posedge clk) begin
		if (start_pulse === 1'b1) begin
			n_start <= n_start + 1;
		end
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One byte access; request held until waitrequest low at a rising edge
	task automatic bus(input logic we, input logic [15:0] i, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge clk);
		addr <= {i, lo};
		wd <= {24'h0, d};
		rd <= !we;
		wr <= we;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (wreq === 1'b0) begin
				break;
			end
		end
		if (n == 20) begin
			n_mismatch++;
			$display("ERROR %0t: no bus answer", $time);
		end
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// High byte at the even index
	task automatic acc16(input logic we, input logic [15:0] i, d, output logic [15:0] q);
		bus(we, i, d[15:8], q[15:8]);
		bus(we, i + 16'h1, d[7:0], q[7:0]);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		seed = 36;
		{n_checks, n_mismatch} = '0;
		{rstn, rd, wr, upd, lo, addr, wd} = '0;
		be = 4'h1;
		for (k = 0; k < 14; k++) eng[k] = 16'h0000;
		rb = '{16'h40BA, 16'h40B8, 16'h40BC, 16'h40BE, 16'h40C0, 16'h40C2, 16'h40C4,
			16'h40CA, 16'h40C8, 16'h40C6, 16'h40D0, 16'h40D2, 16'h40CE, 16'h40D4};
		rw = '{16'h40BA, 16'h40B8, 16'h40CC, 16'h40D4, 16'h40CE};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (k = 0; k < 14; k++) begin
			acc16(1'b0, rb[k], 16'h0000, v);
			chk(v, foc_result_pkg::RST_WORD);
		end
		chk({cq, cd}, {2{foc_result_pkg::RST_FILT_COEF}});
		for (k = 0; k < 10; k++) chk(o16[k], 16'h0000);
		for (p = 0; p < 3; p++) begin
			lim = (p == 0) ? 16'h7FFF : 16'($random(seed));
			for (k = 0; k < 5; k++) begin
				prm[k] = 16'($random(seed));
				acc16(1'b1, 16'h40C2 + 16'(2 * k), prm[k], v);
			end
			ang = 16'($random(seed));
			acc16(1'b1, 16'h40AE, ang, v);
			acc16(1'b1, 16'h40B4, lim, v);
			{kq, kd} = 16'($random(seed));
			bus(1'b1, 16'h40C0, kq, b);
			bus(1'b1, 16'h40C1, kd, b);
			@(posedge clk);
			for (k = 0; k < 14; k++) eng[k] <= (k == 0 && p == 0) ? 16'h8000 : 16'($random(seed));
			upd <= 1'b1;
			@(posedge clk);
			upd <= 1'b0;
			acc16(1'b1, 16'h40BC, ~eng[2], v);
			for (k = 0; k < 14; k++) begin
				acc16(1'b0, rb[k], 16'h0000, v);
				chk(v, eng[k]);
			end
			chk(o16[4], eng[1] + prm[0]);
			chk(o16[5], eng[0] + prm[1]);
			chk(o16[9], eng[0] - lim);
			chk(o16[6], eng[12] + ang);
			chk({cq, cd}, {kq, kd});
			for (k = 0; k < 3; k++) chk(o16[k], prm[k + 2]);
			chk(o16[3], lim);
			acc16(1'b0, 16'h40B4, 16'h0000, v);
			chk(v, lim);
		end
		for (k = 0; k < 5; k++) begin
			w[k] = (k == 0) ? 16'h8000 : 16'($random(seed));
			acc16(1'b1, rw[k], w[k], v);
			acc16(1'b0, rw[k], 16'h0000, v);
			chk(v, w[k]);
		end
		chk(o16[7], w[3]);
		chk(o16[8], w[4]);
		chk(16'(n_start), 16'h0002);
		chk(o16[9], w[0] - lim);
		chk(o16[5], w[0] + prm[1]);
		chk(o16[4], w[1] + prm[0]);
		chk(o16[6], w[2]);
		lo <= 2'h2;
		bus(1'b1, 16'h40D4, 8'h5A, b);
		bus(1'b0, 16'h40D4, 8'h00, b);
		chk({8'h00, b}, 16'h0000);
		lo <= 2'h0;
		be <= 4'h0;
		bus(1'b1, 16'h40D4, ~w[3][15:8], b);
		be <= 4'h1;
		acc16(1'b0, 16'h40D4, 16'h0000, v);
		chk(v, w[3]);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		chk({cq, cd}, 16'hFFFF);
		acc16(1'b0, 16'h40BA, 16'h0000, v);
		chk(v, 16'h0000);
		print_verdict();
	end
endmodule
